// [logic/ccm_clock_mode.sv]
`timescale 1ns/1ps
module ccm_clock_mode (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // straps and configuration
   input  wire logic [2:0]        clock_mode_strap_pins,
   input  wire logic              osc_watchdog_disable,
   // input oscillator clock, sampled
   input  wire logic              xtal_in,
   // generated clock and status
   output logic                   cpu_clk,
   output logic                   cpu_edge,
   output ccm_pkg::ccm_mode_t     clock_mode_straps,
   output logic                   mode_valid,
   output logic                   pll_enable,
   output logic                   osc_fail,
   output logic                   osc_fail_interrupt
);
   typedef struct packed {
      logic                    captured;
      ccm_pkg::ccm_mode_t      mode;
      logic                    xtal;
      logic                    clk;
      logic                    edge_p;
      logic [ccm_pkg::PER_W-1:0] per_cnt;
      logic [ccm_pkg::PER_W-1:0] period;
      logic [ccm_pkg::PER_W:0]   acc;
      logic [3:0]              trans;
   } ccm_st_t;

   ccm_st_t st_r;
   ccm_st_t st_nxt;

   ccm_owd_if owd_if ();

   ccm_owd u_owd (
      .clk_sys (clk_sys),
      .reset   (reset),
      .owd     (owd_if.wdg)
   );

   logic       xtal_rise;
   logic       xtal_tr;
   logic       is_direct;
   logic       is_presc;
   logic       is_pll;
   logic [3:0] edges;
   logic [3:0] resync;
   logic [ccm_pkg::PER_W:0] acc_sum;

   always_comb begin
      unique case (st_r.mode)
         ccm_pkg::CCM_MODE_X4:   begin edges = ccm_pkg::EDGES_X4;   resync = ccm_pkg::RESYNC_X4;   end
         ccm_pkg::CCM_MODE_X3:   begin edges = ccm_pkg::EDGES_X3;   resync = ccm_pkg::RESYNC_X3;   end
         ccm_pkg::CCM_MODE_X2:   begin edges = ccm_pkg::EDGES_X2;   resync = ccm_pkg::RESYNC_X2;   end
         ccm_pkg::CCM_MODE_X5:   begin edges = ccm_pkg::EDGES_X5;   resync = ccm_pkg::RESYNC_X5;   end
         ccm_pkg::CCM_MODE_X1P5: begin edges = ccm_pkg::EDGES_X1P5; resync = ccm_pkg::RESYNC_X1P5; end
         ccm_pkg::CCM_MODE_X2P5: begin edges = ccm_pkg::EDGES_X2P5; resync = ccm_pkg::RESYNC_X2P5; end
         ccm_pkg::CCM_MODE_DIRECT,
         ccm_pkg::CCM_MODE_PRESC: begin edges = 4'h0; resync = 4'h0; end
      endcase
   end

   assign xtal_rise = xtal_in && !st_r.xtal;
   assign xtal_tr   = xtal_in != st_r.xtal;
   assign is_direct = st_r.captured && st_r.mode == ccm_pkg::CCM_MODE_DIRECT;
   assign is_presc  = st_r.captured && st_r.mode == ccm_pkg::CCM_MODE_PRESC;
   assign is_pll    = st_r.captured && !is_direct && !is_presc;
   assign acc_sum   = st_r.acc + {13'h0000, edges};

   // watchdog only guards the non-pll modes
   assign owd_if.enable    = (is_direct || is_presc) && !osc_watchdog_disable;
   assign owd_if.xtal_edge = xtal_tr;

   always_comb begin
      st_nxt        = st_r;
      st_nxt.xtal   = xtal_in;
      st_nxt.edge_p = 1'b0;
      if (!st_r.captured) begin
         // straps still on the pins in the first cycle after release
         st_nxt.captured = 1'b1;
         st_nxt.mode     = ccm_pkg::ccm_mode_t'(clock_mode_strap_pins);
      end else if (owd_if.fail) begin
         if (owd_if.pll_tick) begin
            st_nxt.clk = !st_r.clk;
         end
      end else if (is_direct) begin
         st_nxt.clk = xtal_in;
      end else if (is_presc) begin
         if (xtal_rise) begin
            st_nxt.clk = !st_r.clk;
         end
      end else begin
         // period tracking; clk_sys must be well above the input rate
         if (xtal_rise) begin
            st_nxt.per_cnt = '0;
            st_nxt.period  = st_r.per_cnt + 16'h0001;
         end else if (st_r.per_cnt != 16'hFFFF) begin
            st_nxt.per_cnt = st_r.per_cnt + 16'h0001;
         end
         if (st_r.period != '0) begin
            if (acc_sum >= {1'b0, st_r.period}) begin
               st_nxt.acc = acc_sum - {1'b0, st_r.period};
               st_nxt.clk = !st_r.clk;
            end else begin
               st_nxt.acc = acc_sum;
            end
         end
         if (xtal_tr) begin
            if (st_r.trans + 4'h1 >= resync) begin
               // pull phase back onto the input edge; error is a fraction of a cycle
               st_nxt.trans = 4'h0;
               st_nxt.acc   = '0;
            end else begin
               st_nxt.trans = st_r.trans + 4'h1;
            end
         end
      end
      st_nxt.edge_p = st_nxt.clk != st_r.clk;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st_r      <= '0;
         st_r.mode <= ccm_pkg::MODE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cpu_clk            = st_r.clk;
   assign cpu_edge           = st_r.edge_p;
   assign clock_mode_straps  = st_r.mode;
   assign mode_valid         = st_r.captured;
   assign pll_enable         = is_pll || owd_if.pll_run;
   assign osc_fail           = owd_if.fail;
   assign osc_fail_interrupt = owd_if.fail_pulse;

   AST_STRAP_CAPTURE: assert property (@(posedge clk_sys) disable iff (reset)
      !st_r.captured |=> (mode_valid && clock_mode_straps == $past(clock_mode_strap_pins)))
      else $error("strap code not captured after reset");
   AST_STRAP_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
      mode_valid |=> (mode_valid && $stable(clock_mode_straps)))
      else $error("clock mode changed without reset");
   AST_PRESC_TOGGLE: assert property (@(posedge clk_sys) disable iff (reset)
      (is_presc && !osc_fail && xtal_rise) |=> (cpu_clk != $past(cpu_clk)))
      else $error("prescaler missed an input rising edge");
   AST_PRESC_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
      (is_presc && !osc_fail && !xtal_rise) |=> $stable(cpu_clk))
      else $error("prescaler toggled without an input rising edge");
   AST_DIRECT_FOLLOW: assert property (@(posedge clk_sys) disable iff (reset)
      (is_direct && !osc_fail) |=> (cpu_clk == $past(xtal_in)))
      else $error("direct drive does not follow input");
   AST_DIRECT_PERIOD: assert property (@(posedge clk_sys) disable iff (reset)
      (is_direct && !osc_fail && xtal_rise) |=> ($rose(cpu_clk) && cpu_edge))
      else $error("direct drive period not aligned to input");
   AST_WDG_PLL: assert property (@(posedge clk_sys) disable iff (reset)
      ((is_direct || is_presc) && osc_watchdog_disable) |-> !pll_enable)
      else $error("pll not switched off with watchdog disabled");
   AST_EDGE_MARK: assert property (@(posedge clk_sys) disable iff (reset)
      mode_valid |=> (cpu_edge == (cpu_clk != $past(cpu_clk))))
      else $error("edge marker disagrees with clock");
   AST_PLL_ON: assert property (@(posedge clk_sys) disable iff (reset)
      is_pll |-> (pll_enable && !owd_if.enable))
      else $error("pll not enabled in multiply mode");

   // guards below cover corners the bench rarely reaches, such as a stalled input in every mode
   AST_PLL_NO_FAIL: assert property (@(posedge clk_sys) disable iff (reset)
      is_pll |-> !osc_fail)
      else $error("watchdog failure seen in multiply mode");

   AST_WDG_ON: assert property (@(posedge clk_sys) disable iff (reset)
      ((is_direct || is_presc) && !osc_watchdog_disable) |-> pll_enable)
      else $error("pll not running for enabled watchdog");

   AST_FAIL_CLOCK: assert property (@(posedge clk_sys) disable iff (reset)
      (osc_fail && owd_if.pll_tick) |=> cpu_edge)
      else $error("failed clock did not follow free-running tick");

   AST_FAIL_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
      (osc_fail && !owd_if.pll_tick) |=> $stable(cpu_clk))
      else $error("failed clock moved without a free-running tick");

   AST_FAIL_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
      osc_fail_interrupt |-> osc_fail)
      else $error("failure interrupt without failure flag");

   AST_PULSE_ONCE: assert property (@(posedge clk_sys) disable iff (reset)
      osc_fail_interrupt |=> !osc_fail_interrupt)
      else $error("failure interrupt longer than one cycle");

   AST_FAIL_NOT_MULT: assert property (@(posedge clk_sys) disable iff (reset)
      osc_fail |-> !is_pll)
      else $error("failure flag set while multiplying");

   AST_EDGE_VALID: assert property (@(posedge clk_sys) disable iff (reset)
      !mode_valid |-> !cpu_edge)
      else $error("clock edge before straps captured");

   AST_PLL_PERIOD_WAIT: assert property (@(posedge clk_sys) disable iff (reset)
      (is_pll && st_r.period == '0) |=> $stable(cpu_clk))
      else $error("multiply clock ran before input period known");

   AST_RESYNC_RANGE: assert property (@(posedge clk_sys) disable iff (reset)
      is_pll |-> (st_r.trans < resync))
      else $error("resync transition count out of range");

   AST_PRESC_EDGE: assert property (@(posedge clk_sys) disable iff (reset)
      (is_presc && !osc_fail && xtal_rise) |=> cpu_edge)
      else $error("prescaler edge marker missing");

   AST_DIRECT_QUIET: assert property (@(posedge clk_sys) disable iff (reset)
      (is_direct && $past(is_direct) && !osc_fail && !xtal_tr) |=> !cpu_edge)
      else $error("direct clock edge without input transition");

   AST_WDG_OFF_QUIET: assert property (@(posedge clk_sys) disable iff (reset)
      ((is_direct || is_presc) && osc_watchdog_disable) |=> !osc_fail_interrupt)
      else $error("failure interrupt with watchdog disabled");

   AST_STRAP_DEFAULT: assert property (@(posedge clk_sys) disable iff (reset)
      !mode_valid |-> (clock_mode_straps == ccm_pkg::MODE_RST))
      else $error("mode not at default before capture");
endmodule : ccm_clock_mode

// [include/ccm_pkg.sv]
package ccm_pkg;
   localparam int         CLK_HZ         = 50_000_000;
   localparam int         CLK_PERIOD_NS  = 20;
   localparam int         FREE_RUN_HZ    = 5_000_000;
   localparam logic [7:0] FREE_RUN_DIV   = 8'(CLK_HZ / FREE_RUN_HZ);
   localparam logic [4:0] OWD_OVF_CNT    = 5'h10;
   localparam int         PER_W          = 16;
   localparam logic [3:0] EDGES_X4       = 4'h8;
   localparam logic [3:0] EDGES_X3       = 4'h6;
   localparam logic [3:0] EDGES_X2       = 4'h4;
   localparam logic [3:0] EDGES_X5       = 4'hA;
   localparam logic [3:0] EDGES_X1P5     = 4'h3;
   localparam logic [3:0] EDGES_X2P5     = 4'h5;
   localparam logic [3:0] RESYNC_X4      = 4'h4;
   localparam logic [3:0] RESYNC_X3      = 4'h3;
   localparam logic [3:0] RESYNC_X2      = 4'h2;
   localparam logic [3:0] RESYNC_X5      = 4'h5;
   localparam logic [3:0] RESYNC_X1P5    = 4'h4;
   localparam logic [3:0] RESYNC_X2P5    = 4'h4;

   typedef enum logic [2:0] {
      CCM_MODE_X2P5   = 3'b000,
      CCM_MODE_PRESC  = 3'b001,
      CCM_MODE_X1P5   = 3'b010,
      CCM_MODE_DIRECT = 3'b011,
      CCM_MODE_X5     = 3'b100,
      CCM_MODE_X2     = 3'b101,
      CCM_MODE_X3     = 3'b110,
      CCM_MODE_X4     = 3'b111
   } ccm_mode_t;

   localparam ccm_mode_t MODE_RST = CCM_MODE_X4;
endpackage : ccm_pkg

// [include/ccm_owd_if.sv]
`timescale 1ns/1ps
interface ccm_owd_if;
   logic enable;
   logic xtal_edge;
   logic pll_run;
   logic pll_tick;
   logic fail;
   logic fail_pulse;
   modport core (output enable, output xtal_edge,
                 input pll_run, input pll_tick, input fail, input fail_pulse);
   modport wdg  (input enable, input xtal_edge,
                 output pll_run, output pll_tick, output fail, output fail_pulse);
endinterface : ccm_owd_if

// [logic/ccm_owd.sv]
`timescale 1ns/1ps
module ccm_owd (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // link to clock core
   ccm_owd_if.wdg    owd
);
   typedef struct packed {
      logic [7:0] div;
      logic [4:0] cnt;
      logic       tick;
      logic       fail;
      logic       pulse;
   } ccm_owd_st_t;

   ccm_owd_st_t st_r;
   ccm_owd_st_t st_nxt;

   always_comb begin
      st_nxt       = st_r;
      st_nxt.tick  = 1'b0;
      st_nxt.pulse = 1'b0;
      if (owd.enable) begin
         // free-running oscillator modelled as a divided enable
         if (st_r.div == ccm_pkg::FREE_RUN_DIV - 8'h01) begin
            st_nxt.div  = 8'h00;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.div = st_r.div + 8'h01;
         end
         if (owd.xtal_edge) begin
            st_nxt.cnt = 5'h00;
         end else if (st_r.tick && !st_r.fail) begin
            st_nxt.cnt = st_r.cnt + 5'h01;
            if (st_r.cnt + 5'h01 == ccm_pkg::OWD_OVF_CNT) begin
               st_nxt.fail  = 1'b1;
               st_nxt.pulse = 1'b1;
            end
         end
      end else begin
         // pll off: no ticks, counter parked
         st_nxt.div = 8'h00;
         st_nxt.cnt = 5'h00;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign owd.pll_run    = owd.enable;
   assign owd.pll_tick   = st_r.tick;
   assign owd.fail       = st_r.fail;
   assign owd.fail_pulse = st_r.pulse;

   AST_OWD_OVERFLOW: assert property (@(posedge clk_sys) disable iff (reset)
      (owd.enable && !owd.xtal_edge && st_r.tick && st_r.cnt == 5'h0F && !st_r.fail)
      |=> (owd.fail && owd.fail_pulse))
      else $error("watchdog overflow did not raise fail");
   AST_OWD_STICKY: assert property (@(posedge clk_sys) disable iff (reset)
      owd.fail |=> owd.fail ##1 owd.fail)
      else $error("watchdog fail dropped before reset");
   AST_OWD_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
      (owd.enable && owd.xtal_edge) |=> (st_r.cnt == 5'h00))
      else $error("watchdog counter not cleared by input transition");
endmodule : ccm_owd

// [dv/ccm_xtal_model.sv]
`timescale 1ns/1ps
module ccm_xtal_model (
   // clock
   input  wire logic       clk_sys,
   // waveform control
   input  wire logic       run,
   input  wire logic [7:0] high_cyc,
   input  wire logic [7:0] low_cyc,
   // oscillator output
   output logic            xtal_in
);
   logic [7:0] cnt_r;
   initial begin
      xtal_in = 1'b0;
      cnt_r   = 8'h00;
   end
   // a dead crystal freezes at its level, so stopping keeps the last one
   always @(negedge clk_sys) begin
      if (run) begin
         if (cnt_r + 8'h01 >= (xtal_in ? high_cyc : low_cyc)) begin
            xtal_in <= ~xtal_in;
            cnt_r   <= 8'h00;
         end else begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end
endmodule : ccm_xtal_model

// [dv/cpu_clock_mode_select_tb.sv]
`timescale 1ns/1ps
module cpu_clock_mode_select_tb;
   logic               clk_sys, reset, dis, run, xtal_in;
   logic               cpu_clk, cpu_edge, mode_valid, pll_enable;
   logic               osc_fail, osc_fail_interrupt;
   logic [2:0]         pins;
   logic [7:0]         hi, lo;
   ccm_pkg::ccm_mode_t straps;
   int                 bad_count, checks, edge_cnt, intr_cnt, h, l, w;

   ccm_clock_mode uut (.clk_sys(clk_sys), .reset(reset), .clock_mode_strap_pins(pins),
      .osc_watchdog_disable(dis), .xtal_in(xtal_in), .cpu_clk(cpu_clk),
      .cpu_edge(cpu_edge), .clock_mode_straps(straps), .mode_valid(mode_valid),
      .pll_enable(pll_enable), .osc_fail(osc_fail),
      .osc_fail_interrupt(osc_fail_interrupt));
   ccm_xtal_model osc (.clk_sys(clk_sys), .run(run), .high_cyc(hi), .low_cyc(lo),
      .xtal_in(xtal_in));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (cpu_edge === 1'b1) edge_cnt <= edge_cnt + 1;
      if (osc_fail_interrupt === 1'b1) intr_cnt <= intr_cnt + 1;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // cpu edges per input period: twice the factor
   function automatic int edges(input logic [2:0] c);
      case (c)
         3'h7: return 8;
         3'h6: return 6;
         3'h5: return 4;
         3'h4: return 10;
         3'h2: return 3;
         default: return 5;
      endcase
   endfunction : edges
   task give_verdict;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   task cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   task start(input logic [2:0] c, input logic d);
      reset = 1'b1;
      pins  = c;
      dis   = d;
      run   = 1'b1;
      cyc(12);
      chk(mode_valid, 1'b0);
      chk(osc_fail, 1'b0);
      reset = 1'b0;
      cyc(1);
      chk(straps, c);
      chk(mode_valid, 1'b1);
      pins = 3'($urandom);
      cyc(3);
      chk(straps, c);
      chk(pll_enable, !((c == 3'h1 || c == 3'h3) && d));
   endtask : start
   // cycles until the next cpu clock edge
   task phase(output int n);
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (cpu_edge !== 1'b1 && n < 400);
   endtask : phase
   task halves(output int hh, output int ll);
      int s;
      phase(s);
      if (cpu_clk !== 1'b1) phase(s);
      phase(hh);
      phase(ll);
   endtask : halves

   initial begin
      reset = 1'b1;
      pins = 3'h7;
      dis = 1'b0;
      run = 1'b0;
      hi = 8'h04;
      lo = 8'h04;
      {bad_count, checks, edge_cnt, intr_cnt} = '0;
      void'($urandom(32'hF4D0));
      for (int i = 0; i < 8; i++) start(3'(i), 1'($urandom));
      $display("test straps done");
      repeat (4) begin
         hi = 8'($urandom_range(7, 2));
         lo = 8'($urandom_range(7, 2));
         start(3'h3, 1'($urandom));
         cyc(20);
         halves(h, l);
         chk(h, hi);
         chk(l, lo);
      end
      $display("test direct done");
      hi = 8'h02;
      lo = 8'h04;
      start(3'h1, 1'b0);
      cyc(30);
      halves(h, l);
      chk(h, 6);
      chk(l, 6);
      $display("test prescaler done");
      hi = 8'h3C;
      lo = 8'h3C;
      for (int i = 0; i < 8; i++) begin
         if (i == 1 || i == 3) continue;
         start(3'(i), 1'($urandom));
         cyc(480);
         edge_cnt = 0;
         cyc(480);
         w = 4 * edges(3'(i));
         chk(edge_cnt >= w - 2 && edge_cnt <= w + 2, 1'b1);
      end
      $display("test multiply done");
      hi = 8'h04;
      lo = 8'h04;
      start(3'h3, 1'b0);
      cyc(20);
      intr_cnt = 0;
      run = 1'b0;
      w = 0;
      while (osc_fail !== 1'b1 && w < 400) begin
         cyc(1);
         w++;
      end
      chk(w >= 140 && w <= 180, 1'b1);
      cyc(2);
      chk(intr_cnt, 1);
      halves(h, l);
      chk(h, ccm_pkg::FREE_RUN_DIV);
      run = 1'b1;
      cyc(50);
      chk(osc_fail, 1'b1);
      start(3'h3, 1'b1);
      run = 1'b0;
      cyc(400);
      chk(osc_fail, 1'b0);
      $display("test watchdog done");
      give_verdict();
   end
   // whole run is near 7000 cycles
   initial begin
      #1ms;
      bad_count++;
      give_verdict();
   end
endmodule : cpu_clock_mode_select_tb
